// [design/frtf_map.svh]
// Contract
// - Match A flag sets whenever the counter equals compare value A.
// - Match B flag sets whenever the counter equals compare value B.
// - Wrap flag sets when the counter rolls from all ones to zero.
// - Software writes can only clear these flags; writing one never sets them.
// - A flag clears only after a read showing one, then a zero write.
// - With clear on match A set, counter returns to zero at match A.
// - Match A means the counter and compare value A are equal.
// - Edge select A picks falling (0) or rising (1) edge of capture input A.
// - Edge selects B, C, D pick falling (0) or rising (1) capture edges.
// - Buffer enable A makes capture register C buffer capture register A.
// - Buffer enable B makes capture register D a buffer in the B path.
// - Timer control holds edge selects, buffer enables and clock source select.
// - Buffered B capture moves old B value into D, then loads B.
// - Buffered A mode: input C edge sets its flag, leaves register C alone.
`ifndef FRTF_MAP_SVH
`define FRTF_MAP_SVH

//------------------------------------------------------------
// Widths and sizes
//------------------------------------------------------------
`define FRTF_ADDR_W        8
`define FRTF_CNT_W         16
`define FRTF_NUM_CAP       4
`define FRTF_NUM_STAT      3
`define FRTF_NUM_INT       7

//------------------------------------------------------------
// Register byte offsets
//------------------------------------------------------------
`define FRTF_OFS_CTRL      8'h00
`define FRTF_OFS_STAT      8'h04
`define FRTF_OFS_CAPFLAG   8'h08
`define FRTF_OFS_COUNT     8'h0C
`define FRTF_OFS_CMP_A     8'h10
`define FRTF_OFS_CMP_B     8'h14
`define FRTF_OFS_CAP_A     8'h18
`define FRTF_OFS_CAP_B     8'h1C
`define FRTF_OFS_CAP_C     8'h20
`define FRTF_OFS_CAP_D     8'h24
`define FRTF_OFS_INT_STAT  8'h28
`define FRTF_OFS_INT_MASK  8'h2C

//------------------------------------------------------------
// Field positions and values
//------------------------------------------------------------
`define FRTF_CCLR_BIT      0
`define FRTF_STAT_LSB      1
`define FRTF_CAPFLAG_LSB   4
`define FRTF_CNT_ALL_ONES  16'hFFFF
`define FRTF_CNT_ZERO      16'h0000
`define FRTF_CNT_ONE       16'h0001
`define FRTF_RESP_OKAY     2'h0
`define FRTF_RESP_SLVERR   2'h2

`endif

// [design/frtf_pkg.sv]
`include "frtf_map.svh"

package frtf_pkg;

	typedef logic [`FRTF_CNT_W-1:0] frtf_count_t;

	// Bit 7..4 edge selects A..D, 3 buffer A, 2 buffer B, 1..0 clock source
	typedef struct packed {
		logic [`FRTF_NUM_CAP-1:0] edge_sel;
		logic                     buffer_enable_a;
		logic                     buffer_enable_b;
		logic [1:0]               clock_source;
	} frtf_ctrl_s;

	typedef struct packed {
		frtf_ctrl_s                            ctrl;
		logic                                  clear_on_match_a;
		logic [`FRTF_NUM_STAT-1:0]             stat_flag;
		logic [`FRTF_NUM_STAT-1:0]             stat_arm;
		logic [`FRTF_NUM_CAP-1:0]              cap_flag;
		logic [`FRTF_NUM_CAP-1:0]              cap_arm;
		frtf_count_t                           counter;
		frtf_count_t                           cmp_a;
		frtf_count_t                           cmp_b;
		frtf_count_t [`FRTF_NUM_CAP-1:0]       cap_reg;
		logic [`FRTF_NUM_INT-1:0]              int_status;
		logic [`FRTF_NUM_INT-1:0]              int_mask;
		logic [`FRTF_NUM_CAP-1:0]              sync1;
		logic [`FRTF_NUM_CAP-1:0]              sync2;
		logic [`FRTF_NUM_CAP-1:0]              prev;
		logic                                  aw_held;
		logic [`FRTF_ADDR_W-1:0]               awaddr;
		logic                                  w_held;
		logic [31:0]                           wdata;
		logic [3:0]                            wstrb;
		logic                                  bvalid;
		logic [1:0]                            bresp;
		logic                                  rvalid;
		logic [31:0]                           rdata;
		logic [1:0]                            rresp;
	} frtf_state_s;

endpackage : frtf_pkg

// [design/frtf_top.sv]
`include "frtf_map.svh"

module frtf_top (
	input  wire logic                    CORE_CLK,       // Core clock, 40 MHz
	input  wire logic                    RST_N,          // Async reset, active low
	input  wire logic [`FRTF_ADDR_W-1:0] S_AXI_AWADDR,   // Write address
	input  wire logic                    S_AXI_AWVALID,  // Write address valid
	output logic                         S_AXI_AWREADY,  // Write address ready
	input  wire logic [31:0]             S_AXI_WDATA,    // Write data
	input  wire logic [3:0]              S_AXI_WSTRB,    // Write byte strobes
	input  wire logic                    S_AXI_WVALID,   // Write data valid
	output logic                         S_AXI_WREADY,   // Write data ready
	output logic [1:0]                   S_AXI_BRESP,    // Write response
	output logic                         S_AXI_BVALID,   // Write response valid
	input  wire logic                    S_AXI_BREADY,   // Write response ready
	input  wire logic [`FRTF_ADDR_W-1:0] S_AXI_ARADDR,   // Read address
	input  wire logic                    S_AXI_ARVALID,  // Read address valid
	output logic                         S_AXI_ARREADY,  // Read address ready
	output logic [31:0]                  S_AXI_RDATA,    // Read data
	output logic [1:0]                   S_AXI_RRESP,    // Read response
	output logic                         S_AXI_RVALID,   // Read data valid
	input  wire logic                    S_AXI_RREADY,   // Read data ready
	input  wire logic [`FRTF_NUM_CAP-1:0] CAPTURE_IN,    // Capture inputs, 3=A..0=D
	output logic [`FRTF_CNT_W-1:0]       COUNTER_VALUE,  // Free running counter
	output logic                         IRQ             // Interrupt, active high
);

	//------------------------------------------------------------
	// Helper functions
	//------------------------------------------------------------
	function automatic logic [3:0] flag_clear(
		input logic [3:0] flags,
		input logic [3:0] armed,
		input logic [3:0] wbits,
		input logic       wr
	);
		flag_clear = wr ? (flags & armed & ~wbits) : 4'h0;
	endfunction : flag_clear

	function automatic frtf_pkg::frtf_count_t merge16(
		input frtf_pkg::frtf_count_t old,
		input logic [31:0]           wd,
		input logic [3:0]            be
	);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction : merge16

	function automatic logic [33:0] rd_mux(
		input logic [`FRTF_ADDR_W-1:0] addr,
		input frtf_pkg::frtf_state_s   s
	);
		logic [31:0] d;
		logic [1:0]  r;
		d = 32'h0000_0000;
		r = `FRTF_RESP_OKAY;
		unique case (addr)
			`FRTF_OFS_CTRL:     d[7:0] = s.ctrl;
			`FRTF_OFS_STAT: begin
				d[`FRTF_CCLR_BIT] = s.clear_on_match_a;
				d[`FRTF_STAT_LSB +: `FRTF_NUM_STAT] = s.stat_flag;
			end
			`FRTF_OFS_CAPFLAG:  d[`FRTF_CAPFLAG_LSB +: `FRTF_NUM_CAP] = s.cap_flag;
			`FRTF_OFS_COUNT:    d[`FRTF_CNT_W-1:0] = s.counter;
			`FRTF_OFS_CMP_A:    d[`FRTF_CNT_W-1:0] = s.cmp_a;
			`FRTF_OFS_CMP_B:    d[`FRTF_CNT_W-1:0] = s.cmp_b;
			`FRTF_OFS_CAP_A:    d[`FRTF_CNT_W-1:0] = s.cap_reg[3];
			`FRTF_OFS_CAP_B:    d[`FRTF_CNT_W-1:0] = s.cap_reg[2];
			`FRTF_OFS_CAP_C:    d[`FRTF_CNT_W-1:0] = s.cap_reg[1];
			`FRTF_OFS_CAP_D:    d[`FRTF_CNT_W-1:0] = s.cap_reg[0];
			`FRTF_OFS_INT_STAT: d[`FRTF_NUM_INT-1:0] = s.int_status;
			`FRTF_OFS_INT_MASK: d[`FRTF_NUM_INT-1:0] = s.int_mask;
			default:            r = `FRTF_RESP_SLVERR;
		endcase
		rd_mux = {r, d};
	endfunction : rd_mux

	//------------------------------------------------------------
	// State and decode
	//------------------------------------------------------------
	frtf_pkg::frtf_state_s          st_ff;
	frtf_pkg::frtf_state_s          nxt_st;
	logic [`FRTF_NUM_CAP-1:0]       ev;
	logic                           wr_fire;
	logic                           rd_fire;
	logic                           wr_ctrl;
	logic                           wr_stat;
	logic                           wr_capf;
	logic                           wr_int;
	logic                           rd_stat;
	logic                           rd_capf;
	logic                           wr_known;
	logic                           match_a;
	logic                           match_b;
	logic                           cnt_wr;
	logic                           cnt_clear;
	logic                           wrap;
	logic [`FRTF_NUM_STAT-1:0]      set_stat;
	logic [`FRTF_NUM_STAT-1:0]      clr_stat;
	logic [`FRTF_NUM_CAP-1:0]       clr_cap;
	logic [33:0]                    rd_word;
	logic [3:0]                     stat_clr_full;
	logic [`FRTF_NUM_STAT-1:0]      stat_clash;
	logic [`FRTF_NUM_CAP-1:0]       cap_quiet;
	logic [`FRTF_NUM_CAP-1:0]       cap_unarmed;

	assign wr_fire  = st_ff.aw_held & st_ff.w_held & ~st_ff.bvalid;
	assign rd_fire  = S_AXI_ARVALID & ~st_ff.rvalid;
	assign wr_ctrl  = wr_fire && st_ff.awaddr == `FRTF_OFS_CTRL && st_ff.wstrb[0];
	assign wr_stat  = wr_fire && st_ff.awaddr == `FRTF_OFS_STAT && st_ff.wstrb[0];
	assign wr_capf  = wr_fire && st_ff.awaddr == `FRTF_OFS_CAPFLAG && st_ff.wstrb[0];
	assign wr_int   = wr_fire && st_ff.awaddr == `FRTF_OFS_INT_STAT && st_ff.wstrb[0];
	assign rd_stat  = rd_fire && S_AXI_ARADDR == `FRTF_OFS_STAT;
	assign rd_capf  = rd_fire && S_AXI_ARADDR == `FRTF_OFS_CAPFLAG;
	assign rd_word  = rd_mux(S_AXI_ARADDR, st_ff);
	assign wr_known = rd_mux(st_ff.awaddr, st_ff) >> 32 == 34'h0;

	// Edge detect on synchronised pins, polarity from the edge selects
	assign ev = (st_ff.sync2 & ~st_ff.prev & st_ff.ctrl.edge_sel)
		| (~st_ff.sync2 & st_ff.prev & ~st_ff.ctrl.edge_sel);

	assign match_a   = st_ff.counter == st_ff.cmp_a;
	assign match_b   = st_ff.counter == st_ff.cmp_b;
	assign cnt_wr    = wr_fire && st_ff.awaddr == `FRTF_OFS_COUNT && st_ff.wstrb[1:0] != 2'h0;
	assign cnt_clear = st_ff.clear_on_match_a & match_a;
	assign wrap      = st_ff.counter == `FRTF_CNT_ALL_ONES && !cnt_clear && !cnt_wr;
	assign set_stat  = {match_a, match_b, wrap};

	// Clear only bits that were read as one and are now written zero
	assign stat_clr_full = flag_clear({1'b0, st_ff.stat_flag}, {1'b0, st_ff.stat_arm},
		{1'b0, st_ff.wdata[`FRTF_STAT_LSB +: `FRTF_NUM_STAT]}, wr_stat);
	assign clr_stat = stat_clr_full[`FRTF_NUM_STAT-1:0];
	assign clr_cap  = flag_clear(st_ff.cap_flag, st_ff.cap_arm,
		st_ff.wdata[`FRTF_CAPFLAG_LSB +: `FRTF_NUM_CAP], wr_capf);
	assign stat_clash  = set_stat & clr_stat;
	assign cap_quiet   = ~st_ff.cap_flag & ~ev;
	assign cap_unarmed = st_ff.cap_flag & ~st_ff.cap_arm;

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;

		nxt_st.sync1 = CAPTURE_IN;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.prev  = st_ff.sync2;

		// Counter: software load, then clear on match A, else count
		if (cnt_wr) begin
			nxt_st.counter = merge16(st_ff.counter, st_ff.wdata, st_ff.wstrb);
		end else if (cnt_clear) begin
			nxt_st.counter = `FRTF_CNT_ZERO;
		end else begin
			nxt_st.counter = st_ff.counter + `FRTF_CNT_ONE;
		end
		if (wr_fire && st_ff.awaddr == `FRTF_OFS_CMP_A) begin
			nxt_st.cmp_a = merge16(st_ff.cmp_a, st_ff.wdata, st_ff.wstrb);
		end
		if (wr_fire && st_ff.awaddr == `FRTF_OFS_CMP_B) begin
			nxt_st.cmp_b = merge16(st_ff.cmp_b, st_ff.wdata, st_ff.wstrb);
		end

		// Flags: set wins, writes only clear
		nxt_st.stat_flag = set_stat | (st_ff.stat_flag & ~clr_stat);
		nxt_st.cap_flag  = ev | (st_ff.cap_flag & ~clr_cap);
		nxt_st.stat_arm  = (wr_stat ? '0 : st_ff.stat_arm) | (rd_stat ? st_ff.stat_flag : '0);
		nxt_st.cap_arm   = (wr_capf ? '0 : st_ff.cap_arm) | (rd_capf ? st_ff.cap_flag : '0);

		if (wr_stat) begin
			nxt_st.clear_on_match_a = st_ff.wdata[`FRTF_CCLR_BIT];
		end
		if (wr_ctrl) begin
			nxt_st.ctrl = st_ff.wdata[7:0];
		end

		// Capture paths
		if (ev[3]) begin
			if (st_ff.ctrl.buffer_enable_a) begin
				nxt_st.cap_reg[1] = st_ff.cap_reg[3];
			end
			nxt_st.cap_reg[3] = st_ff.counter;
		end
		if (ev[2]) begin
			if (st_ff.ctrl.buffer_enable_b) begin
				nxt_st.cap_reg[0] = st_ff.cap_reg[2];
			end
			nxt_st.cap_reg[2] = st_ff.counter;
		end
		if (ev[1] && !st_ff.ctrl.buffer_enable_a) begin
			nxt_st.cap_reg[1] = st_ff.counter;
		end
		if (ev[0] && !st_ff.ctrl.buffer_enable_b) begin
			nxt_st.cap_reg[0] = st_ff.counter;
		end

		// Interrupt status, write one to clear, set wins
		nxt_st.int_status = {set_stat, ev}
			| (st_ff.int_status & ~(wr_int ? st_ff.wdata[`FRTF_NUM_INT-1:0] : '0));
		if (wr_fire && st_ff.awaddr == `FRTF_OFS_INT_MASK && st_ff.wstrb[0]) begin
			nxt_st.int_mask = st_ff.wdata[`FRTF_NUM_INT-1:0];
		end

		// AXI write side
		if (S_AXI_AWVALID && !st_ff.aw_held) begin
			nxt_st.aw_held = 1'b1;
			nxt_st.awaddr  = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !st_ff.w_held) begin
			nxt_st.w_held = 1'b1;
			nxt_st.wdata  = S_AXI_WDATA;
			nxt_st.wstrb  = S_AXI_WSTRB;
		end
		if (wr_fire) begin
			nxt_st.aw_held = 1'b0;
			nxt_st.w_held  = 1'b0;
			nxt_st.bvalid  = 1'b1;
			nxt_st.bresp   = wr_known ? `FRTF_RESP_OKAY : `FRTF_RESP_SLVERR;
		end else if (st_ff.bvalid && S_AXI_BREADY) begin
			nxt_st.bvalid = 1'b0;
		end

		// AXI read side
		if (rd_fire) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = rd_word[31:0];
			nxt_st.rresp  = rd_word[33:32];
		end else if (st_ff.rvalid && S_AXI_RREADY) begin
			nxt_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------
	assign S_AXI_AWREADY = ~st_ff.aw_held;
	assign S_AXI_WREADY  = ~st_ff.w_held;
	assign S_AXI_BVALID  = st_ff.bvalid;
	assign S_AXI_BRESP   = st_ff.bresp;
	assign S_AXI_ARREADY = ~st_ff.rvalid;
	assign S_AXI_RVALID  = st_ff.rvalid;
	assign S_AXI_RDATA   = st_ff.rdata;
	assign S_AXI_RRESP   = st_ff.rresp;
	assign COUNTER_VALUE = st_ff.counter;
	assign IRQ           = |(st_ff.int_status & st_ff.int_mask);

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	sequence seq_rise_a;
		st_ff.sync2[3] && !st_ff.prev[3] && st_ff.ctrl.edge_sel[3];
	endsequence

	sequence seq_fall_d;
		!st_ff.sync2[0] && st_ff.prev[0] && !st_ff.ctrl.edge_sel[0] && !st_ff.ctrl.buffer_enable_b;
	endsequence

	sequence seq_unarmed_write;
		wr_stat && st_ff.stat_flag[2] && !st_ff.stat_arm[2];
	endsequence

	chk_match_a_flag: assert property (
		match_a |=> st_ff.stat_flag[2])
		else $error("match A flag not set");
	chk_match_b_flag: assert property (
		match_b |=> st_ff.stat_flag[1] && st_ff.int_status[5])
		else $error("match B flag not set");
	chk_wrap_flag: assert property (
		st_ff.counter == `FRTF_CNT_ALL_ONES && !cnt_wr && !cnt_clear
		|=> st_ff.counter == `FRTF_CNT_ZERO && st_ff.stat_flag[0])
		else $error("wrap not flagged");
	chk_write_no_set: assert property (
		!st_ff.stat_flag[2] && !match_a |=> !st_ff.stat_flag[2])
		else $error("flag set without match");
	chk_clear_needs_read: assert property (
		seq_unarmed_write |=> st_ff.stat_flag[2])
		else $error("flag cleared without prior read");
	chk_clear_on_match: assert property (
		cnt_clear && !cnt_wr |=> st_ff.counter == `FRTF_CNT_ZERO)
		else $error("counter not cleared at match A");
	chk_free_count: assert property (
		!st_ff.clear_on_match_a && !cnt_wr
		|=> st_ff.counter == $past(st_ff.counter) + `FRTF_CNT_ONE)
		else $error("counter did not advance");
	chk_capture_rise_a: assert property (
		seq_rise_a |=> st_ff.cap_reg[3] == $past(st_ff.counter) && st_ff.cap_flag[3])
		else $error("rising capture A missed");
	chk_capture_fall_d: assert property (
		seq_fall_d |=> st_ff.cap_reg[0] == $past(st_ff.counter))
		else $error("falling capture D missed");
	chk_buffer_a_move: assert property (
		ev[3] && st_ff.ctrl.buffer_enable_a |=> st_ff.cap_reg[1] == $past(st_ff.cap_reg[3]))
		else $error("capture A not buffered into C");
	chk_buffer_b_move: assert property (
		ev[2] && st_ff.ctrl.buffer_enable_b
		|=> st_ff.cap_reg[0] == $past(st_ff.cap_reg[2])
		&& st_ff.cap_reg[2] == $past(st_ff.counter))
		else $error("capture B not buffered into D");
	chk_buffer_c_hold: assert property (
		ev[1] && !ev[3] && st_ff.ctrl.buffer_enable_a
		|=> $stable(st_ff.cap_reg[1]) && st_ff.cap_flag[1])
		else $error("capture C changed in buffer mode");
	chk_set_wins: assert property (
		stat_clash != '0 |=> (st_ff.stat_flag & $past(stat_clash)) == $past(stat_clash))
		else $error("set lost to clear");
	chk_reset_clear: assert property (
		$rose(RST_N) |-> st_ff.ctrl == '0 && st_ff.stat_flag == '0
		&& st_ff.cap_flag == '0 && !st_ff.clear_on_match_a)
		else $error("state not cleared by reset");
	chk_cap_no_set: assert property (
		cap_quiet != '0 |=> (st_ff.cap_flag & $past(cap_quiet)) == '0)
		else $error("capture flag set without edge");
	chk_cap_needs_read: assert property (
		cap_unarmed != '0 |=> (st_ff.cap_flag & $past(cap_unarmed)) == $past(cap_unarmed))
		else $error("capture flag cleared without prior read");
	chk_wrap_no_set: assert property (
		!st_ff.stat_flag[0] && !wrap |=> !st_ff.stat_flag[0])
		else $error("wrap flag set without rollover");
	chk_buffer_d_hold: assert property (
		ev[0] && !ev[2] && st_ff.ctrl.buffer_enable_b
		|=> $stable(st_ff.cap_reg[0]) && st_ff.cap_flag[0])
		else $error("capture D changed in buffer mode");
	chk_cmp_a_hold: assert property (
		!(wr_fire && st_ff.awaddr == `FRTF_OFS_CMP_A) |=> $stable(st_ff.cmp_a))
		else $error("compare A changed without write");
	chk_ctrl_hold: assert property (
		!wr_ctrl |=> $stable(st_ff.ctrl))
		else $error("timer control changed without write");
	chk_clear_bit_hold: assert property (
		!wr_stat |=> $stable(st_ff.clear_on_match_a))
		else $error("clear on match bit changed without write");
	chk_arm_drop: assert property (
		wr_stat && !rd_stat |=> st_ff.stat_arm == '0)
		else $error("status arm kept after write");

endmodule : frtf_top

// [dv/test_frtf_top.sv]
`include "frtf_map.svh"

module test_frtf_top;
	timeunit 1ns;
	timeprecision 1ps;

	//------------------------------------------------------------
	// Signals
	//------------------------------------------------------------
	logic                          core_clk = 1'b0;
	logic                          rst_n    = 1'b0;
	logic [`FRTF_ADDR_W-1:0]       awaddr   = '0;
	logic                          awvalid  = 1'b0;
	logic                          awready;
	logic [31:0]                   wdata    = '0;
	logic [3:0]                    wstrb    = 4'hF;
	logic                          wvalid   = 1'b0;
	logic                          wready;
	logic [1:0]                    bresp;
	logic                          bvalid;
	logic                          bready   = 1'b0;
	logic [`FRTF_ADDR_W-1:0]       araddr   = '0;
	logic                          arvalid  = 1'b0;
	logic                          arready;
	logic [31:0]                   rdata;
	logic [1:0]                    rresp;
	logic                          rvalid;
	logic                          rready   = 1'b0;
	logic [`FRTF_NUM_CAP-1:0]      cap_in   = '0;
	logic [`FRTF_CNT_W-1:0]        cnt_out;
	logic                          irq;
	int                            n_fail     = 0;
	int                            num_checks = 0;
	logic [31:0]                   v;
	logic [31:0]                   a1;
	logic [31:0]                   b1;
	logic [1:0]                    resp;

	always #12.5 core_clk = ~core_clk;

	frtf_top u_frtf_top (
		.CORE_CLK(core_clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.CAPTURE_IN(cap_in), .COUNTER_VALUE(cnt_out), .IRQ(irq)
	);

	//------------------------------------------------------------
	// Tasks
	//------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wt

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!((awvalid === 1'b0 || awready) && (wvalid === 1'b0 || wready)));
		while (bvalid !== 1'b1) @(posedge core_clk);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
	endtask : w

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge core_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge core_clk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		check(n, d, e);
	endtask : rc

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	//------------------------------------------------------------
	// Watchdog
	//------------------------------------------------------------
	initial begin
		#(25ns * 20000);
		n_fail++;
		complete_run();
	end

	//------------------------------------------------------------
	// Tests
	//------------------------------------------------------------
	initial begin
		wt(5);
		rst_n <= 1'b1;
		rc(`FRTF_OFS_CTRL, 32'h0000_0000, "ctrl reset");
		rc(`FRTF_OFS_CAPFLAG, 32'h0000_0000, "capture flags reset");
		rc(`FRTF_OFS_INT_MASK, 32'h0000_0000, "mask reset");
		w(`FRTF_OFS_CTRL, 32'h0000_00FF);
		rc(`FRTF_OFS_CTRL, 32'h0000_00FF, "ctrl all ones");
		rd(8'h30, v, resp);
		check("unmapped read resp", {30'h0, resp}, {30'h0, `FRTF_RESP_SLVERR});
		wr(8'h30, 32'h0000_0001, resp);
		check("unmapped write resp", {30'h0, resp}, {30'h0, `FRTF_RESP_SLVERR});
		w(`FRTF_OFS_CTRL, 32'h0000_0000);
		// Compare matches and read-then-zero clearing
		w(`FRTF_OFS_CMP_A, 32'h0000_1010);
		w(`FRTF_OFS_CMP_B, 32'h0000_1018);
		w(`FRTF_OFS_COUNT, 32'h0000_1000);
		wt(60);
		rc(`FRTF_OFS_STAT, 32'h0000_000C, "match flags set");
		w(`FRTF_OFS_STAT, 32'h0000_0004);
		w(`FRTF_OFS_STAT, 32'h0000_0000);
		rc(`FRTF_OFS_STAT, 32'h0000_0004, "clear needs prior read");
		w(`FRTF_OFS_STAT, 32'h0000_0000);
		rc(`FRTF_OFS_STAT, 32'h0000_0000, "flags cleared");
		w(`FRTF_OFS_STAT, 32'h0000_000E);
		rc(`FRTF_OFS_STAT, 32'h0000_0000, "write one no set");
		// Wrap from all ones
		w(`FRTF_OFS_COUNT, 32'h0000_FFF0);
		wt(40);
		rc(`FRTF_OFS_STAT, 32'h0000_0002, "wrap flag");
		w(`FRTF_OFS_STAT, 32'h0000_0000);
		// Clear on match A
		w(`FRTF_OFS_CMP_A, 32'h0000_0040);
		w(`FRTF_OFS_STAT, 32'h0000_0001);
		w(`FRTF_OFS_COUNT, 32'h0000_0000);
		wt(150);
		rd(`FRTF_OFS_COUNT, v, resp);
		check("counter bounded", {31'h0, v <= 32'h40}, 32'h1);
		w(`FRTF_OFS_STAT, 32'h0000_0000);
		wt(150);
		rd(`FRTF_OFS_COUNT, v, resp);
		check("counter passes match", {31'h0, v > 32'h40}, 32'h1);
		// Edge selects, both polarities on all four inputs
		for (int e = 1; e >= 0; e--) begin
			w(`FRTF_OFS_CTRL, (e == 1) ? 32'h0000_00F0 : 32'h0000_0000);
			cap_in <= (e == 1) ? 4'hF : 4'h0;
			wt(10);
			rd(`FRTF_OFS_CAPFLAG, v, resp);
			w(`FRTF_OFS_CAPFLAG, 32'h0000_0000);
			cap_in <= (e == 1) ? 4'h0 : 4'hF;
			wt(10);
			rc(`FRTF_OFS_CAPFLAG, 32'h0000_0000, "other edge ignored");
			cap_in <= (e == 1) ? 4'hF : 4'h0;
			wt(10);
			rc(`FRTF_OFS_CAPFLAG, 32'h0000_00F0, "selected edge");
		end
		// Buffer modes
		w(`FRTF_OFS_CTRL, 32'h0000_00FC);
		cap_in <= 4'hC;
		wt(10);
		rd(`FRTF_OFS_CAP_A, a1, resp);
		rd(`FRTF_OFS_CAP_B, b1, resp);
		cap_in <= 4'h0;
		wt(10);
		cap_in <= 4'hC;
		wt(10);
		rc(`FRTF_OFS_CAP_C, a1, "buffer c holds old a");
		rc(`FRTF_OFS_CAP_D, b1, "buffer d holds old b");
		rd(`FRTF_OFS_CAP_B, v, resp);
		check("b reloaded", {31'h0, v !== b1}, 32'h1);
		rd(`FRTF_OFS_CAPFLAG, v, resp);
		w(`FRTF_OFS_CAPFLAG, 32'h0000_0000);
		cap_in <= 4'h2;
		wt(10);
		rc(`FRTF_OFS_CAPFLAG, 32'h0000_0020, "c flag in buffer mode");
		rc(`FRTF_OFS_CAP_C, a1, "c unchanged");
		// Interrupt status, mask and output
		w(`FRTF_OFS_INT_STAT, 32'h0000_007F);
		rc(`FRTF_OFS_INT_STAT, 32'h0000_0000, "int status cleared");
		cap_in <= 4'h3;
		wt(10);
		rc(`FRTF_OFS_INT_STAT, 32'h0000_0001, "int status d");
		check("irq masked", {31'h0, irq}, 32'h0);
		w(`FRTF_OFS_INT_MASK, 32'h0000_0001);
		check("irq raised", {31'h0, irq}, 32'h1);
		w(`FRTF_OFS_INT_STAT, 32'h0000_0001);
		check("irq cleared", {31'h0, irq}, 32'h0);
		// Byte strobes, then a match held every cycle against a clear
		wstrb <= 4'h1;
		w(`FRTF_OFS_CMP_B, 32'h0000_AB55);
		wstrb <= 4'hF;
		rc(`FRTF_OFS_CMP_B, 32'h0000_1055, "byte strobe merge");
		w(`FRTF_OFS_CMP_A, 32'h0000_0000);
		w(`FRTF_OFS_STAT, 32'h0000_0001);
		w(`FRTF_OFS_COUNT, 32'h0000_0000);
		rc(`FRTF_OFS_STAT, 32'h0000_0009, "held match flag");
		w(`FRTF_OFS_STAT, 32'h0000_0001);
		rc(`FRTF_OFS_STAT, 32'h0000_0009, "set wins over clear");
		rc(`FRTF_OFS_COUNT, 32'h0000_0000, "counter held at zero");
		check("counter output", {16'h0, cnt_out}, 32'h0);
		complete_run();
	end
endmodule : test_frtf_top
